// ==== src/acs_pkg.sv ====
/*
 * constants, types and register decode for the converter control block.
 * assumes a single 20 MHz system clock and an AXI4-Lite register bus
 * with 32-bit data; registers sit at four times their index.
 */
// Operation
// - single conversion end sets done flag
// - done clears only by write 0 after reading 1
// - no end interrupt while enable bit low
// - writing start bit one begins conversion
// - single mode clears start bit at end
// - scan bit zero means one-shot single mode
// - conversion finishes within 134 clock states
// - channel field picks input, zero is channel 0
// - trigger edges ignored while trigger disabled
// - channel 0 result lands in result A
package acs_pkg;
    localparam int ADDR_W = 18;
    // register indices, byte address is index times four
    localparam logic [15:0] IDX_RESULT_A    = 16'hFFB0;
    localparam logic [15:0] IDX_CTRL_STATUS = 16'hFFB8;
    localparam logic [15:0] IDX_TRIG_CTRL   = 16'hFFB9;
    localparam logic [15:0] IDX_EVT_STATUS  = 16'hFFC0;
    localparam logic [15:0] IDX_EVT_MASK    = 16'hFFC1;
    // conv_ctrl_status fields
    localparam int BIT_DONE  = 7;
    localparam int BIT_IE    = 6;
    localparam int BIT_START = 5;
    localparam int BIT_SCAN  = 4;
    localparam int BIT_CKS   = 3;
    localparam int CH_LSB    = 0;
    localparam int CH_W      = 3;
    // conv_trigger_ctrl field
    localparam int BIT_EXTERNAL_TRIGGER_ENABLE  = 7;
    // event status and mask bits
    localparam int EVT_END   = 0;
    localparam int EVT_TRIG  = 1;
    localparam int EVT_BUSY  = 2;
    localparam int EVT_W     = 3;
    // reset values
    localparam logic [7:0]       CTRL_RST   = 8'h00;
    localparam logic [EVT_W-1:0] EVT_RST    = 3'h0;
    localparam logic [15:0]      RESULT_RST = 16'h0000;
    // conversion time in clock states; one state is one aclk period
    localparam int CLK_HZ           = 20_000_000;
    localparam int CONV_STATES_SLOW = 134;
    localparam int CONV_STATES_FAST = 70;
    localparam int CONV_OVERHEAD    = 2;
    localparam logic [7:0] CONV_LOAD_SLOW = 8'(CONV_STATES_SLOW - CONV_OVERHEAD);
    localparam logic [7:0] CONV_LOAD_FAST = 8'(CONV_STATES_FAST - CONV_OVERHEAD);
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        REG_NONE, REG_RES_A, REG_CTRL, REG_TRIG, REG_EVT_ST, REG_EVT_MSK
    } acs_reg_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } acs_state_t;

    // byte address to register; low two bits must be zero
    function automatic acs_reg_t acs_decode(input logic [ADDR_W-1:0] a);
        acs_reg_t r;
        r = REG_NONE;
        if (a[1:0] == 2'h0) begin
            if (a[ADDR_W-1:2] == IDX_RESULT_A) r = REG_RES_A;
            else if (a[ADDR_W-1:2] == IDX_CTRL_STATUS) r = REG_CTRL;
            else if (a[ADDR_W-1:2] == IDX_TRIG_CTRL) r = REG_TRIG;
            else if (a[ADDR_W-1:2] == IDX_EVT_STATUS) r = REG_EVT_ST;
            else if (a[ADDR_W-1:2] == IDX_EVT_MASK) r = REG_EVT_MSK;
        end
        return r;
    endfunction
endpackage

// ==== src/acs_trig_edge.sv ====
/*
 * falling edge detector for the external trigger pin.
 * assumes the pin is already synchronous to aclk and idles high.
 */
`timescale 1ns/1ps
module acs_trig_edge (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic external_trigger_pin,
    input  wire logic enable,
    output logic      start_pulse
);
    logic pin_prev_ff;
    logic pulse_ff;

    // remember last pin level, idle high
    always_ff @(posedge aclk) begin
        if (!aresetn) pin_prev_ff <= 1'h1;
        else pin_prev_ff <= external_trigger_pin;
    end

    // edges seen while disabled are dropped, not remembered
    always_ff @(posedge aclk) begin
        if (!aresetn) pulse_ff <= 1'h0;
        else pulse_ff <= enable & pin_prev_ff & ~external_trigger_pin;
    end

    assign start_pulse = pulse_ff;
endmodule

// ==== src/acs_conv_timer.sv ====
/*
 * conversion timer: counts one conversion and pulses done at its end.
 * assumes start only arrives when no conversion is running, or at the
 * very cycle done is pulsed (back to back scan).
 */
`timescale 1ns/1ps
module acs_conv_timer (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic start,
    input  wire logic fast,
    output logic      done
);
    logic [7:0] cnt_ff;
    logic       run_ff;
    logic       done_ff;

    // load at start, count down to zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 8'h00;
            run_ff <= 1'h0;
        end else if (start) begin
            cnt_ff <= fast ? acs_pkg::CONV_LOAD_FAST : acs_pkg::CONV_LOAD_SLOW;
            run_ff <= 1'h1;
        end else if (run_ff) begin
            if (cnt_ff == 8'h00) run_ff <= 1'h0;
            else cnt_ff <= cnt_ff - 8'h01;
        end
    end

    // one pulse per finished conversion
    always_ff @(posedge aclk) begin
        if (!aresetn) done_ff <= 1'h0;
        else done_ff <= run_ff & (cnt_ff == 8'h00) & ~start;
    end

    assign done = done_ff;
endmodule

// ==== src/acs_top.sv ====
/*
 * converter control and status: registers on AXI4-Lite, start by
 * software or external trigger, single and scan modes, done flag,
 * result register and interrupts.
 * assumes the analog front end presents the selected channel's sample
 * on analog_sample_data while a conversion runs; one clock domain.
 */
`timescale 1ns/1ps
module acs_top (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [acs_pkg::ADDR_W-1:0] s_awaddr,
    input  wire logic                      s_awvalid,
    output logic                           s_awready,
    input  wire logic [31:0]               s_wdata,
    input  wire logic [3:0]                s_wstrb,
    input  wire logic                      s_wvalid,
    output logic                           s_wready,
    output logic [1:0]                     s_bresp,
    output logic                           s_bvalid,
    input  wire logic                      s_bready,
    input  wire logic [acs_pkg::ADDR_W-1:0] s_araddr,
    input  wire logic                      s_arvalid,
    output logic                           s_arready,
    output logic [31:0]                    s_rdata,
    output logic [1:0]                     s_rresp,
    output logic                           s_rvalid,
    input  wire logic                      s_rready,
    input  wire logic                      external_trigger_pin,
    input  wire logic [15:0]               analog_sample_data,
    output logic [2:0]                     analog_channel_sel,
    output logic                           conv_end_irq,
    output logic                           evt_irq
);
    logic                       awready_ff;
    logic                       wready_ff;
    logic                       aw_held_ff;
    logic                       w_held_ff;
    logic [acs_pkg::ADDR_W-1:0] awaddr_ff;
    logic [7:0]                 wdata_ff;
    logic                       wlane_ff;
    logic                       bvalid_ff;
    logic [1:0]                 bresp_ff;
    logic                       arready_ff;
    logic                       rvalid_ff;
    logic [31:0]                rdata_ff;
    logic [1:0]                 rresp_ff;
    logic                       done_ff;
    logic                       ie_ff;
    logic                       start_ff;
    logic                       scan_ff;
    logic                       cks_ff;
    logic [2:0]                 ch_ff;
    logic                       external_trigger_enable_ff;
    logic                       clr_armed_ff;
    logic [15:0]                result_a_ff;
    logic [acs_pkg::EVT_W-1:0]  evt_st_ff;
    logic [acs_pkg::EVT_W-1:0]  evt_msk_ff;
    logic [2:0]                 cur_ch_ff;
    logic                       conv_end_irq_ff;
    logic                       evt_irq_ff;
    acs_pkg::acs_state_t        state_ff;
    acs_pkg::acs_reg_t          wr_sel;
    acs_pkg::acs_reg_t          rd_sel;
    logic                       aw_hs;
    logic                       w_hs;
    logic                       ar_hs;
    logic                       wr_go;
    logic                       wr_ctrl;
    logic                       idle;
    logic                       sw_start;
    logic                       trig_start;
    logic                       go;
    logic                       refused;
    logic                       conv_done;
    logic                       last_ch;
    logic                       pass_end;
    logic                       keep_scan;
    logic                       timer_start;
    logic                       done_clr;
    logic                       scan_sel;
    logic [2:0]                 ch_sel;
    logic                       cks_sel;
    logic [acs_pkg::EVT_W-1:0]  evt_set;

    // bus handshakes and decode
    assign aw_hs   = s_awvalid & awready_ff;
    assign w_hs    = s_wvalid & wready_ff;
    assign ar_hs   = s_arvalid & arready_ff;
    assign wr_go   = aw_held_ff & w_held_ff & ~bvalid_ff;
    assign wr_sel  = acs_pkg::acs_decode(awaddr_ff);
    assign rd_sel  = acs_pkg::acs_decode(s_araddr);
    assign wr_ctrl = wr_go & wlane_ff & (wr_sel == acs_pkg::REG_CTRL);

    // start sources and conversion sequencing
    assign idle       = (state_ff == acs_pkg::ST_IDLE);
    assign sw_start   = wr_ctrl & wdata_ff[acs_pkg::BIT_START];
    assign go         = idle & (sw_start | trig_start);
    assign refused    = ~idle & (sw_start | trig_start);
    assign last_ch    = ~scan_ff | (cur_ch_ff == ch_ff);
    assign pass_end   = conv_done & last_ch;
    assign keep_scan  = scan_ff & start_ff;
    assign timer_start = go | (conv_done & keep_scan);
    // a write of 0 clears only after the flag was seen as 1
    assign done_clr   = wr_ctrl & ~wdata_ff[acs_pkg::BIT_DONE] & clr_armed_ff;
    // mode and channel written together with start take effect at once
    assign scan_sel   = wr_ctrl ? wdata_ff[acs_pkg::BIT_SCAN] : scan_ff;
    assign ch_sel     = wr_ctrl ? wdata_ff[acs_pkg::CH_LSB +: acs_pkg::CH_W] : ch_ff;
    assign cks_sel    = (wr_ctrl & idle) ? wdata_ff[acs_pkg::BIT_CKS] : cks_ff;
    assign evt_set    = {refused, go & trig_start, pass_end};

    acs_trig_edge u_trig (
        .aclk                 (aclk),
        .aresetn              (aresetn),
        .external_trigger_pin (external_trigger_pin),
        .enable               (external_trigger_enable_ff),
        .start_pulse          (trig_start)
    );

    acs_conv_timer u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (timer_start),
        .fast    (cks_sel),
        .done    (conv_done)
    );

    // write address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'h0;
            aw_held_ff <= 1'h0;
            awaddr_ff  <= '0;
        end else begin
            awready_ff <= ~awready_ff & s_awvalid & ~aw_held_ff & ~bvalid_ff;
            if (aw_hs) begin
                aw_held_ff <= 1'h1;
                awaddr_ff  <= s_awaddr;
            end else if (wr_go) aw_held_ff <= 1'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_ff <= 1'h0;
            w_held_ff <= 1'h0;
            wdata_ff  <= 8'h00;
            wlane_ff  <= 1'h0;
        end else begin
            wready_ff <= ~wready_ff & s_wvalid & ~w_held_ff & ~bvalid_ff;
            if (w_hs) begin
                w_held_ff <= 1'h1;
                wdata_ff  <= s_wdata[7:0];
                wlane_ff  <= s_wstrb[0];
            end else if (wr_go) w_held_ff <= 1'h0;
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'h0;
            bresp_ff  <= acs_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'h1;
            bresp_ff  <= (wr_sel == acs_pkg::REG_NONE) ? acs_pkg::RESP_SLVERR
                                                       : acs_pkg::RESP_OKAY;
        end else if (s_bready) bvalid_ff <= 1'h0;
    end

    // read channel, data come from a register one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'h0;
            rvalid_ff  <= 1'h0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= acs_pkg::RESP_OKAY;
        end else begin
            arready_ff <= ~arready_ff & s_arvalid & ~rvalid_ff;
            if (ar_hs) begin
                rvalid_ff <= 1'h1;
                rresp_ff  <= acs_pkg::RESP_OKAY;
                unique case (rd_sel)
                    acs_pkg::REG_RES_A:   rdata_ff <= {16'h0000, result_a_ff};
                    acs_pkg::REG_CTRL:    rdata_ff <= {24'h00_0000, done_ff, ie_ff,
                                                       start_ff, scan_ff, cks_ff, ch_ff};
                    acs_pkg::REG_TRIG:    rdata_ff <= {24'h00_0000, external_trigger_enable_ff, 7'h00};
                    acs_pkg::REG_EVT_ST:  rdata_ff <= {29'h0000_0000, evt_st_ff};
                    acs_pkg::REG_EVT_MSK: rdata_ff <= {29'h0000_0000, evt_msk_ff};
                    acs_pkg::REG_NONE: begin
                        rdata_ff <= 32'h0000_0000;
                        rresp_ff <= acs_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_rready) rvalid_ff <= 1'h0;
        end
    end

    // clear arming: a read showing the flag set, dropped by the next control register write
    always_ff @(posedge aclk) begin
        if (!aresetn) clr_armed_ff <= 1'h0;
        else if (ar_hs && rd_sel == acs_pkg::REG_CTRL && done_ff) clr_armed_ff <= 1'h1;
        else if (wr_ctrl) clr_armed_ff <= 1'h0;
    end

    // done flag; a new end beats a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) done_ff <= 1'h0;
        else if (pass_end) done_ff <= 1'h1;
        else if (done_clr) done_ff <= 1'h0;
    end

    // control bits; mode, clock and channel frozen while converting
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ie_ff   <= acs_pkg::CTRL_RST[acs_pkg::BIT_IE];
            scan_ff <= acs_pkg::CTRL_RST[acs_pkg::BIT_SCAN];
            cks_ff  <= acs_pkg::CTRL_RST[acs_pkg::BIT_CKS];
            ch_ff   <= acs_pkg::CTRL_RST[acs_pkg::CH_LSB +: acs_pkg::CH_W];
        end else if (wr_ctrl) begin
            ie_ff <= wdata_ff[acs_pkg::BIT_IE];
            if (idle) begin
                scan_ff <= wdata_ff[acs_pkg::BIT_SCAN];
                cks_ff  <= wdata_ff[acs_pkg::BIT_CKS];
                ch_ff   <= wdata_ff[acs_pkg::CH_LSB +: acs_pkg::CH_W];
            end
        end
    end

    // start bit: set by either source, self clears in single mode
    always_ff @(posedge aclk) begin
        if (!aresetn) start_ff <= acs_pkg::CTRL_RST[acs_pkg::BIT_START];
        else if (go) start_ff <= 1'h1;
        else if (conv_done && !scan_ff) start_ff <= 1'h0;
        else if (wr_ctrl && !wdata_ff[acs_pkg::BIT_START] && scan_ff) start_ff <= 1'h0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) external_trigger_enable_ff <= acs_pkg::CTRL_RST[acs_pkg::BIT_EXTERNAL_TRIGGER_ENABLE];
        else if (wr_go && wlane_ff && wr_sel == acs_pkg::REG_TRIG)
            external_trigger_enable_ff <= wdata_ff[acs_pkg::BIT_EXTERNAL_TRIGGER_ENABLE];
    end

    // sequencer: single mode converts once, scan loops until start cleared
    always_ff @(posedge aclk) begin
        if (!aresetn) state_ff <= acs_pkg::ST_IDLE;
        else begin
            unique case (state_ff)
                acs_pkg::ST_IDLE: if (go) state_ff <= acs_pkg::ST_CONV;
                acs_pkg::ST_CONV: if (conv_done && !keep_scan) state_ff <= acs_pkg::ST_IDLE;
                default: state_ff <= acs_pkg::ST_IDLE;
            endcase
        end
    end

    // channel being converted; scan walks 0 up to the field value
    always_ff @(posedge aclk) begin
        if (!aresetn) cur_ch_ff <= 3'h0;
        else if (go) cur_ch_ff <= scan_sel ? 3'h0 : ch_sel;
        else if (conv_done && scan_ff) cur_ch_ff <= last_ch ? 3'h0 : cur_ch_ff + 3'h1;
    end

    // only channel 0 has a result register; other channels are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) result_a_ff <= acs_pkg::RESULT_RST;
        else if (conv_done && cur_ch_ff == 3'h0) result_a_ff <= analog_sample_data;
    end

    // sticky events, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_st_ff  <= acs_pkg::EVT_RST;
            evt_msk_ff <= acs_pkg::EVT_RST;
        end else begin
            if (wr_go && wlane_ff && wr_sel == acs_pkg::REG_EVT_ST)
                evt_st_ff <= (evt_st_ff & ~wdata_ff[acs_pkg::EVT_W-1:0]) | evt_set;
            else evt_st_ff <= evt_st_ff | evt_set;
            if (wr_go && wlane_ff && wr_sel == acs_pkg::REG_EVT_MSK)
                evt_msk_ff <= wdata_ff[acs_pkg::EVT_W-1:0];
        end
    end

    // interrupt outputs, registered so they never glitch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_end_irq_ff <= 1'h0;
            evt_irq_ff      <= 1'h0;
        end else begin
            conv_end_irq_ff <= done_ff & ie_ff;
            evt_irq_ff      <= |(evt_st_ff & evt_msk_ff);
        end
    end

    assign s_awready          = awready_ff;
    assign s_wready           = wready_ff;
    assign s_bvalid           = bvalid_ff;
    assign s_bresp            = bresp_ff;
    assign s_arready          = arready_ff;
    assign s_rvalid           = rvalid_ff;
    assign s_rdata            = rdata_ff;
    assign s_rresp            = rresp_ff;
    assign analog_channel_sel = cur_ch_ff;
    assign conv_end_irq       = conv_end_irq_ff;
    assign evt_irq            = evt_irq_ff;

    sequence seq_single_end;
        conv_done && !scan_ff;
    endsequence

    sequence seq_sw_start;
        idle && sw_start;
    endsequence

    chk_done_on_end: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_single_end |=> done_ff) else $error("done flag not set at end");

    chk_done_held: assert property (@(posedge aclk) disable iff (!aresetn)
        done_ff && !done_clr |=> done_ff) else $error("done flag lost");

    chk_irq_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        !ie_ff |=> !conv_end_irq_ff) else $error("end irq while disabled");

    chk_start_begins: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_sw_start |=> state_ff == acs_pkg::ST_CONV && start_ff)
        else $error("start did not begin conversion");

    chk_start_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_single_end |=> !start_ff) else $error("start bit not cleared");

    chk_single_once: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_single_end |=> idle) else $error("single mode did not stop");

    chk_conv_bound: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_sw_start |-> ##[1:134] conv_done) else $error("conversion too long");

    chk_chan_select: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_sw_start and !scan_sel |=> analog_channel_sel == $past(ch_sel))
        else $error("wrong channel selected");

    chk_trig_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
        !external_trigger_enable_ff |=> !trig_start) else $error("trigger taken while disabled");

    chk_result_ch0: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_done && cur_ch_ff == 3'h0 |=> result_a_ff == $past(analog_sample_data))
        else $error("channel 0 result not stored");

    chk_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        done_ff && ie_ff |=> conv_end_irq_ff) else $error("end irq missing");

    chk_result_first: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(done_ff) && $past(cur_ch_ff) == 3'h0 |-> result_a_ff == $past(analog_sample_data))
        else $error("flag set before result");
endmodule

// ==== tb/acs_front_model.sv ====
/*
 * analog front end and external trigger source for the converter bench.
 * assumes the bench sets the level and pulses trig_req after a clock edge.
 */
`timescale 1ns/1ps
module acs_front_model (
    input  wire logic        aclk,
    input  wire logic [2:0]  analog_channel_sel,
    input  wire logic [15:0] level,
    input  wire logic        trig_req,
    output logic [15:0]      analog_sample_data,
    output logic             external_trigger_pin
);
    logic [1:0] low_cnt_ff = 2'h0;
    // each channel differs, so a wrong channel shows in the result
    assign analog_sample_data = level ^ {13'h0000, analog_channel_sel};
    // pin idles high, pulls low for two clocks per request
    always_ff @(posedge aclk) begin
        if (trig_req) begin
            low_cnt_ff <= 2'h2;
        end else if (low_cnt_ff != 2'h0) begin
            low_cnt_ff <= low_cnt_ff - 2'h1;
        end
    end
    assign external_trigger_pin = (low_cnt_ff == 2'h0);
endmodule

// ==== tb/testbench.sv ====
/*
 * self-checking bench for the converter control block.
 * assumes the register map at four times the package indices.
 */
`timescale 1ns/1ps
module testbench;
    localparam logic [17:0] A_CTL = {acs_pkg::IDX_CTRL_STATUS, 2'b00};
    localparam logic [17:0] A_RES = {acs_pkg::IDX_RESULT_A, 2'b00};
    localparam logic [17:0] A_TRG = {acs_pkg::IDX_TRIG_CTRL, 2'b00};
    localparam logic [17:0] A_EST = {acs_pkg::IDX_EVT_STATUS, 2'b00};
    localparam logic [17:0] A_EMK = {acs_pkg::IDX_EVT_MASK, 2'b00};
    localparam logic [17:0] A_BAD = 18'h3_FF10;
    logic        aclk = 1'b0, aresetn = 1'b0, trig_req = 1'b0;
    logic [17:0] s_awaddr = 18'h0_0000, s_araddr = 18'h0_0000;
    logic [31:0] s_wdata = 32'h0000_0000;
    logic [3:0]  s_wstrb = 4'h1;
    logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_arvalid = 1'b0;
    logic        s_bready = 1'b1, s_rready = 1'b1;
    logic [15:0] level = 16'h0000;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, seen;
    logic        conv_end_irq, evt_irq, external_trigger_pin;
    logic [1:0]  s_bresp, s_rresp, rsp;
    logic [31:0] s_rdata, rd;
    logic [15:0] analog_sample_data, lvl0;
    logic [2:0]  analog_channel_sel, ch;
    int          bad_count = 0, n_compared = 0, cyc = 0, t0;

    always #25 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;

    acs_front_model i_front (.aclk(aclk), .analog_channel_sel(analog_channel_sel),
        .level(level), .trig_req(trig_req), .analog_sample_data(analog_sample_data),
        .external_trigger_pin(external_trigger_pin));
    acs_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
        .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
        .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .external_trigger_pin(external_trigger_pin), .analog_sample_data(analog_sample_data),
        .analog_channel_sel(analog_channel_sel), .conv_end_irq(conv_end_irq),
        .evt_irq(evt_irq));

    // expected control word from its fields
    function automatic logic [31:0] exp_ctrl(input logic dn, ie, st, input logic [2:0] c);
        return {24'h00_0000, dn, ie, st, 2'b00, c};
    endfunction

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ready may come on either channel first; each drops on its own
    task automatic axw(input logic [17:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_awready) begin
                aw_ok = 1'b1;
                s_awvalid <= 1'b0;
            end
            if (s_wready) begin
                w_ok = 1'b1;
                s_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_bvalid);
        rsp = s_bresp;
    endtask

    task automatic axr(input logic [17:0] a);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_arready);
        s_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_rvalid);
        rd = s_rdata;
        rsp = s_rresp;
    endtask

    task automatic fire();
        trig_req <= 1'b1;
        @(posedge aclk);
        trig_req <= 1'b0;
        repeat (150) @(posedge aclk);
    endtask

    // hang guard: roughly five and a half times the expected run
    initial begin
        #(50 * 5000);
        bad_count++;
        close_out();
    end

    initial begin
        void'($urandom(36));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(A_CTL);
        chk_word(rd, 32'h0000_0000);
        axr(A_BAD);
        chk_bit(logic'(rsp === acs_pkg::RESP_SLVERR), 1'b1);
        axw(A_BAD, 32'h0000_0001);
        chk_bit(logic'(rsp === acs_pkg::RESP_SLVERR), 1'b1);
        lvl0 = 16'($urandom);
        level <= lvl0;
        t0 = cyc;
        axw(A_CTL, exp_ctrl(1'b0, 1'b1, 1'b1, 3'h0));
        axr(A_CTL);
        chk_word(rd, exp_ctrl(1'b0, 1'b1, 1'b1, 3'h0));
        chk_bit(logic'(analog_channel_sel === 3'h0), 1'b1);
        while (!conv_end_irq) @(posedge aclk);
        // three bus cycles, the conversion, the done flag register, then the irq register
        chk_bit(logic'(cyc - t0 <= 3 + acs_pkg::CONV_STATES_SLOW + 2), 1'b1);
        axr(A_RES);
        chk_word(rd, {16'h0000, lvl0});
        axr(A_CTL);
        chk_word(rd, exp_ctrl(1'b1, 1'b1, 1'b0, 3'h0));
        axw(A_CTL, exp_ctrl(1'b0, 1'b1, 1'b0, 3'h0));
        axr(A_CTL);
        chk_word(rd, exp_ctrl(1'b0, 1'b1, 1'b0, 3'h0));
        chk_bit(conv_end_irq, 1'b0);
        // interrupt disabled; clear attempted without a prior read
        axw(A_CTL, exp_ctrl(1'b0, 1'b0, 1'b1, 3'h0));
        seen = 1'b0;
        repeat (140) begin
            @(posedge aclk);
            seen |= conv_end_irq;
        end
        chk_bit(seen, 1'b0);
        axw(A_CTL, 32'h0000_0000);
        axr(A_CTL);
        chk_word(rd, exp_ctrl(1'b1, 1'b0, 1'b0, 3'h0));
        axw(A_CTL, 32'h0000_0000);
        axr(A_CTL);
        chk_word(rd, 32'h0000_0000);
        // other channel: result A keeps the channel 0 value
        ch = 3'($urandom_range(7, 1));
        level <= 16'($urandom);
        axw(A_CTL, exp_ctrl(1'b0, 1'b0, 1'b1, ch));
        @(posedge aclk);
        chk_bit(logic'(analog_channel_sel === ch), 1'b1);
        repeat (140) @(posedge aclk);
        axr(A_RES);
        chk_word(rd, {16'h0000, lvl0});
        axr(A_CTL);
        axw(A_CTL, 32'h0000_0000);
        fire();
        axr(A_CTL);
        chk_word(rd, 32'h0000_0000);
        axw(A_TRG, 32'h0000_0080);
        axw(A_EMK, 32'h0000_0002);
        axw(A_EST, 32'h0000_0007);
        fire();
        chk_bit(evt_irq, 1'b1);
        axr(A_CTL);
        chk_word(rd, exp_ctrl(1'b1, 1'b0, 1'b0, 3'h0));
        axw(A_EST, 32'h0000_0002);
        @(posedge aclk);
        chk_bit(evt_irq, 1'b0);
        // fast clock select written together with start must apply at once
        axw(A_CTL, 32'h0000_0000);
        t0 = cyc;
        axw(A_CTL, 32'h0000_0068);
        while (!conv_end_irq) @(posedge aclk);
        chk_bit(logic'(cyc - t0 <= 3 + acs_pkg::CONV_STATES_FAST + 2), 1'b1);
        axr(A_RES);
        chk_word(rd, {16'h0000, level});
        close_out();
    end
endmodule
